// File: design/sfm_regs.svh
// Opcodes, status field positions, address limits and reset values of the memory slave.
`ifndef SFM_REGS_SVH
`define SFM_REGS_SVH

// ************************************************************
// Opcodes
// ************************************************************
`define SFM_OP_SET_LATCH 8'h06
`define SFM_OP_CLEAR_LATCH 8'h04
`define SFM_OP_STATUS_READ 8'h05
`define SFM_OP_STATUS_WRITE 8'h01
`define SFM_OP_READ 8'h03
`define SFM_OP_FAST_READ 8'h0B
`define SFM_OP_WRITE 8'h02

// ************************************************************
// Status register fields
// ************************************************************
`define SFM_ST_LATCH_BIT 1
`define SFM_ST_BP_LOW_BIT 2
`define SFM_ST_BP_HIGH_BIT 3
`define SFM_ST_PIN_EN_BIT 7
`define SFM_STATUS_RESET 8'h00

// ************************************************************
// Array geometry and protected ranges
// ************************************************************
`define SFM_ADDR_W 14
`define SFM_DEPTH 16384
`define SFM_ADDR_LAST 14'h3FFF
`define SFM_QUARTER_BASE 14'h3000
`define SFM_HALF_BASE 14'h2000

`endif

// File: design/sfm_pkg.sv
// Types shared by the memory slave front end and its storage array.
`include "sfm_regs.svh"

package sfm_pkg;

    typedef enum logic [3:0] {
        ph_idle,
        ph_opcode,
        ph_addr,
        ph_dummy,
        ph_rdata,
        ph_wdata,
        ph_stat_rd,
        ph_stat_wr,
        ph_done,
        ph_ignore
    } sfm_phase_type;

    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] sck_s;
        logic [1:0] si_s;
        logic [1:0] hold_s;
        logic [1:0] wp_s;
        logic cs_d;
        logic sck_d;
        sfm_phase_type phase;
        logic mode3;
        logic skip_fall;
        logic paused;
        logic [2:0] bit_cnt;
        logic [6:0] in_sr;
        logic addr_second;
        logic fast;
        logic wr_cmd;
        logic [`SFM_ADDR_W-1:0] addr;
        logic [7:0] out_sr;
        logic drive;
        logic clear_at_end;
        logic blocked;
        logic write_enable_latch;
        logic ppe;
        logic [1:0] bp;
        logic mem_we;
        logic [`SFM_ADDR_W-1:0] mem_waddr;
        logic [7:0] mem_wdata;
    } sfm_main_type;

    typedef struct packed {
        logic [`SFM_DEPTH-1:0][7:0] cells;
        logic [7:0] rdata;
    } sfm_mem_type;

endpackage

// File: design/sfm_array.sv
// Byte-wide storage array of the memory slave with one write port and one registered read port.
`timescale 1ns/10ps
`include "sfm_regs.svh"

module sfm_array
    import sfm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic we,
    input wire logic [`SFM_ADDR_W-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [`SFM_ADDR_W-1:0] raddr,
    output logic [7:0] rdata
);

    sfm_mem_type st;
    sfm_mem_type next_st;

    // ************************************************************
    // Storage
    // ************************************************************
    // The cells are left out of reset, as their contents must outlive it.
    always_comb
    begin
        next_st = st;
        if (we)
        begin
            next_st.cells[waddr] = wdata;
        end
        next_st.rdata = st.cells[raddr];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st.rdata <= 8'h00;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;

endmodule

// File: design/sfm_slave.sv
// Serial bus slave front end of a 16K x 8 nonvolatile memory with status and write protection.
`timescale 1ns/10ps
`include "sfm_regs.svh"

module sfm_slave
    import sfm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so,
    output logic so_oe_n
);

    sfm_main_type st;
    sfm_main_type next_st;
    logic [7:0] mem_rdata;
    logic [7:0] status;
    logic sel_fall;
    logic sel_rise;
    logic clk_rise;
    logic clk_fall;
    logic run;
    logic byte_ev;
    logic load_ev;
    logic [7:0] rx_byte;

    // ************************************************************
    // Protected range check
    // ************************************************************
    function automatic logic prot_hit(input logic [1:0] bp, input logic [`SFM_ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        case (bp)
            2'b01: hit = (a >= `SFM_QUARTER_BASE);
            2'b10: hit = (a >= `SFM_HALF_BASE);
            2'b11: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // ************************************************************
    // Edge and event decode
    // ************************************************************
    assign status = {st.ppe, 3'b000, st.bp, st.write_enable_latch, 1'b0};
    assign sel_fall = st.cs_d & ~st.cs_s[1];
    assign sel_rise = ~st.cs_d & st.cs_s[1];
    assign clk_rise = ~st.sck_d & st.sck_s[1];
    assign clk_fall = st.sck_d & ~st.sck_s[1];
    assign run = ~st.paused & ~st.cs_s[1];
    assign byte_ev = run & clk_rise & ~sel_fall & (st.bit_cnt == 3'd7);
    assign load_ev = run & clk_fall & ~sel_fall & ~sel_rise & ~st.skip_fall
        & (st.bit_cnt == 3'd0) & ((st.phase == ph_rdata) | (st.phase == ph_stat_rd));
    assign rx_byte = {st.in_sr, st.si_s[1]};

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        next_st = st;
        next_st.cs_s = {st.cs_s[0], cs_n};
        next_st.sck_s = {st.sck_s[0], sck};
        next_st.si_s = {st.si_s[0], si};
        next_st.hold_s = {st.hold_s[0], hold_n};
        next_st.wp_s = {st.wp_s[0], wp_n};
        next_st.cs_d = st.cs_s[1];
        next_st.sck_d = st.sck_s[1];
        next_st.mem_we = 1'b0;
        if (!st.sck_s[1])
        begin
            next_st.paused = ~st.hold_s[1];
        end
        if (sel_fall)
        begin
            next_st.phase = ph_opcode;
            next_st.bit_cnt = 3'd0;
            next_st.mode3 = st.sck_s[1];
            next_st.skip_fall = st.sck_s[1];
            next_st.drive = 1'b0;
            next_st.clear_at_end = 1'b0;
            next_st.blocked = 1'b0;
            next_st.addr_second = 1'b0;
        end
        else if (sel_rise)
        begin
            if (st.clear_at_end)
            begin
                next_st.write_enable_latch = 1'b0;
            end
            next_st.phase = ph_idle;
            next_st.drive = 1'b0;
        end
        else if (run && clk_rise)
        begin
            next_st.skip_fall = 1'b0;
            next_st.in_sr = rx_byte[6:0];
            next_st.bit_cnt = st.bit_cnt + 3'd1;
            if (st.bit_cnt == 3'd7)
            begin
                case (st.phase)
                    ph_opcode:
                    begin
                        next_st.fast = 1'b0;
                        next_st.wr_cmd = 1'b0;
                        case (rx_byte)
                            `SFM_OP_SET_LATCH:
                            begin
                                next_st.write_enable_latch = 1'b1;
                                next_st.phase = ph_done;
                            end
                            `SFM_OP_CLEAR_LATCH:
                            begin
                                next_st.clear_at_end = 1'b1;
                                next_st.phase = ph_done;
                            end
                            `SFM_OP_STATUS_READ:
                            begin
                                next_st.phase = ph_stat_rd;
                            end
                            `SFM_OP_STATUS_WRITE:
                            begin
                                next_st.clear_at_end = 1'b1;
                                next_st.phase = ph_stat_wr;
                            end
                            `SFM_OP_READ:
                            begin
                                next_st.phase = ph_addr;
                            end
                            `SFM_OP_FAST_READ:
                            begin
                                next_st.fast = 1'b1;
                                next_st.phase = ph_addr;
                            end
                            `SFM_OP_WRITE:
                            begin
                                next_st.wr_cmd = 1'b1;
                                next_st.clear_at_end = 1'b1;
                                next_st.phase = ph_addr;
                            end
                            default:
                            begin
                                next_st.phase = ph_ignore;
                            end
                        endcase
                    end
                    ph_addr:
                    begin
                        next_st.addr_second = 1'b1;
                        if (!st.addr_second)
                        begin
                            next_st.addr[13:8] = rx_byte[5:0];
                        end
                        else
                        begin
                            next_st.addr[7:0] = rx_byte;
                            if (st.wr_cmd)
                            begin
                                next_st.phase = ph_wdata;
                            end
                            else if (st.fast)
                            begin
                                next_st.phase = ph_dummy;
                            end
                            else
                            begin
                                next_st.phase = ph_rdata;
                            end
                        end
                    end
                    ph_dummy:
                    begin
                        next_st.phase = ph_rdata;
                    end
                    ph_wdata:
                    begin
                        // The protect pin plays no part here; only the blocked flag, the latch and the range do.
                        if (!st.blocked && st.write_enable_latch && !prot_hit(st.bp, st.addr))
                        begin
                            next_st.mem_we = 1'b1;
                            next_st.mem_waddr = st.addr;
                            next_st.mem_wdata = rx_byte;
                            next_st.addr = st.addr + 14'h0001;
                        end
                        else
                        begin
                            next_st.blocked = 1'b1;
                        end
                    end
                    ph_stat_wr:
                    begin
                        if (st.write_enable_latch && !(st.ppe && !st.wp_s[1]))
                        begin
                            next_st.ppe = rx_byte[`SFM_ST_PIN_EN_BIT];
                            next_st.bp[0] = rx_byte[`SFM_ST_BP_LOW_BIT];
                            next_st.bp[1] = rx_byte[`SFM_ST_BP_HIGH_BIT];
                        end
                        next_st.phase = ph_done;
                    end
                    default:
                    begin
                        next_st.phase = st.phase;
                    end
                endcase
            end
        end
        else if (run && clk_fall)
        begin
            next_st.skip_fall = 1'b0;
            if (load_ev)
            begin
                next_st.drive = 1'b1;
                if (st.phase == ph_stat_rd)
                begin
                    next_st.out_sr = status;
                end
                else
                begin
                    next_st.out_sr = mem_rdata;
                    next_st.addr = st.addr + 14'h0001;
                end
            end
            else if (!st.skip_fall)
            begin
                next_st.out_sr = {st.out_sr[6:0], 1'b0};
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Latch, pin enable and protect bits start at their shipped default.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.cs_s <= 2'b11;
            st.cs_d <= 1'b1;
            st.hold_s <= 2'b11;
            st.wp_s <= 2'b11;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    sfm_array u_array (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .we(st.mem_we),
        .waddr(st.mem_waddr),
        .wdata(st.mem_wdata),
        .raddr(st.addr),
        .rdata(mem_rdata)
    );

    assign so = st.out_sr[7];
    assign so_oe_n = ~(st.drive & ~st.paused & ~st.cs_s[1]);

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_status_load;
        ce && load_ev && st.phase == ph_stat_rd;
    endsequence

    sequence s_select_end;
        ce && sel_rise;
    endsequence

    AST_STATUS_ZERO_BITS: assert property (
        s_status_load |=> st.out_sr[0] == 1'b0 && st.out_sr[6:4] == 3'b000
            && st.out_sr[1] == $past(st.write_enable_latch))
        else $error("Status byte shows nonzero fixed bits or wrong latch.");

    AST_LATCH_SET: assert property (
        ce && byte_ev && st.phase == ph_opcode && rx_byte == `SFM_OP_SET_LATCH
            |=> st.write_enable_latch ##1 (st.write_enable_latch || sel_rise || $past(sel_rise)))
        else $error("Set-latch command did not set the latch.");

    AST_LATCH_CLEAR: assert property (
        s_select_end ##0 st.clear_at_end |=> !st.write_enable_latch)
        else $error("Latch not cleared at end of a write-type command.");

    AST_STATUS_WRITE_KEEPS_LATCH: assert property (
        ce && byte_ev && st.phase == ph_stat_wr |=> st.write_enable_latch == $past(st.write_enable_latch))
        else $error("Status write changed the latch directly.");

    AST_PIN_BLOCKS_STATUS: assert property (
        ce && byte_ev && st.phase == ph_stat_wr && st.ppe && !st.wp_s[1]
            |=> $stable(st.bp) && $stable(st.ppe))
        else $error("Status write passed while the protect pin blocks it.");

    AST_ARRAY_WRITE_ALLOWED: assert property (
        st.mem_we |-> st.write_enable_latch && !prot_hit(st.bp, st.mem_waddr)
            && st.addr == st.mem_waddr + 14'h0001)
        else $error("Array byte written without latch or inside protected range.");

    AST_BLOCKED_STAYS: assert property (
        ce && st.blocked && st.phase == ph_wdata && !sel_rise && !sel_fall
            |=> !st.mem_we && $stable(st.addr))
        else $error("Burst write advanced after reaching a protected address.");

    AST_ADDR_WRAP: assert property (
        ce && load_ev && st.phase == ph_rdata && st.addr == `SFM_ADDR_LAST
            |=> st.addr == 14'h0000)
        else $error("Read address failed to wrap to zero.");

    AST_RELEASE_ON_DESELECT: assert property (
        s_select_end |=> so_oe_n && st.phase == ph_idle)
        else $error("Output still driven after select rose.");

    AST_PAUSE_RELEASES: assert property (
        ce && st.paused && !sel_fall && !sel_rise |-> so_oe_n ##1 $stable(st.bit_cnt))
        else $error("Paused device drove the output or shifted.");

    AST_UNKNOWN_QUIET: assert property (
        st.phase == ph_ignore |-> so_oe_n && !st.mem_we)
        else $error("Unknown opcode led to output drive or a write.");

endmodule

// File: verification/sfm_master.sv
// Serial bus master model that drives the link pins of the memory slave.
`timescale 1ns/10ps

module sfm_master
(
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe_n
);
    // ************************************************************
    // State
    // ************************************************************
    logic m3;
    logic drv;
    logic [7:0] rxd;
    // The data out line has a pull-up on the board, so a released line reads high.
    wire so_line = so_oe_n ? 1'b1 : so;

    initial
    begin
        cs_n = 1;
        sck = 0;
        si = 0;
        hold_n = 1;
        m3 = 0;
        drv = 0;
        rxd = 0;
    end

    // ************************************************************
    // Transfers
    // ************************************************************
    // Data out is read late in the high phase, well after it settles from the fall.
    task automatic bits(input logic [7:0] tx, input int n);
        for (int i = 7; i > 7 - n; i--)
        begin
            sck = 0;
            si = tx[i];
            #80;
            sck = 1;
            #70;
            rxd = {rxd[6:0], so_line};
            if (so_oe_n === 1'b0)
                drv = 1;
            #10;
        end
    endtask

    task automatic sel(input logic mode3);
        m3 = mode3;
        sck = mode3;
        si = ~si;
        drv = 0;
        #80;
        cs_n = 0;
        #80;
    endtask

    task automatic desel();
        #80;
        sck = m3;
        si = ~si;
        #80;
        cs_n = 1;
        #160;
    endtask

    // The pause pin only moves while the serial clock is low; the clock toggles meanwhile.
    task automatic pause(input logic on);
        sck = 0;
        #80;
        hold_n = ~on;
        #80;
        if (on)
        begin
            sck = 1;
            #80;
            sck = 0;
            #80;
        end
    endtask
endmodule

// File: verification/sfm_slave_tb.sv
// Self-checking bench for the memory slave front end.
`timescale 1ns/10ps
`include "sfm_regs.svh"

module sfm_slave_tb;
    // ************************************************************
    // Signals
    // ************************************************************
    logic clk_sys = 0;
    logic rst_n;
    logic ce;
    logic wp_n;
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic so;
    logic so_oe_n;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] m [0:16383];
    logic [13:0] st;
    logic [13:0] starts [3] = '{14'h1FFF, 14'h2FFF, 14'h3FFF};

    always #10 clk_sys = ~clk_sys;

    sfm_slave DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cs_n(cs_n), .sck(sck),
        .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n));
    sfm_master mst (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so),
        .so_oe_n(so_oe_n));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic print_verdict();
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] op);
        mst.sel(0);
        mst.bits(op, 8);
        mst.desel();
    endtask

    task automatic rsr(input logic mode3, input logic [7:0] exp);
        mst.sel(mode3);
        mst.bits(8'h05, 8);
        mst.bits(8'hA5, 8);
        chk(mst.rxd, exp);
        mst.desel();
    endtask

    task automatic wsr(input logic [7:0] v);
        cmd(8'h06);
        mst.sel(0);
        mst.bits(8'h01, 8);
        mst.bits(v, 8);
        mst.desel();
    endtask

    // The two spare address bits are sent as ones; the slave must drop them.
    task automatic wr(input logic en, input logic [13:0] a, input logic [7:0] d0,
        input logic [7:0] d1);
        if (en)
            cmd(8'h06);
        mst.sel(0);
        mst.bits(8'h02, 8);
        mst.bits({2'b11, a[13:8]}, 8);
        mst.bits(a[7:0], 8);
        mst.bits(d0, 8);
        mst.bits(d1, 8);
        mst.desel();
    endtask

    task automatic rd(input logic fast, input logic [13:0] a);
        logic [13:0] nx;
        nx = a + 14'h1;
        mst.sel(0);
        mst.bits(fast ? 8'h0B : 8'h03, 8);
        mst.bits({2'b00, a[13:8]}, 8);
        mst.bits(a[7:0], 8);
        if (fast)
            mst.bits(8'h5A, 8);
        mst.bits(8'hC3, 8);
        chk(mst.rxd, m[a]);
        mst.bits(8'h3C, 8);
        chk(mst.rxd, m[nx]);
        mst.desel();
        chk({7'h0, so_oe_n}, 8'h01);
    endtask

    function automatic logic prot(input logic [1:0] b, input logic [13:0] a);
        return b == 2'b11 || (b == 2'b10 && a >= 14'h2000) || (b == 2'b01 && a >= 14'h3000);
    endfunction

    // Once a byte is refused the address freezes, so everything after it is lost.
    task automatic mw(input logic [1:0] b, input logic [13:0] a, input logic [7:0] d0,
        input logic [7:0] d1);
        logic [13:0] nx;
        nx = a + 14'h1;
        if (!prot(b, a))
        begin
            m[a] = d0;
            if (!prot(b, nx))
                m[nx] = d1;
        end
    endtask

    // ************************************************************
    // Timeout
    // ************************************************************
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            print_verdict();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        wp_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        #2;
        rst_n = 1;
        #80;
        rsr(0, 8'h00);
        cmd(8'h06);
        rsr(1, 8'h02);
        cmd(8'h04);
        rsr(0, 8'h00);
        // A frozen slave must miss a whole set-latch command on the link.
        ce = 1'b0;
        cmd(8'h06);
        ce = 1'b1;
        rsr(0, 8'h00);
        wsr(8'hFF);
        rsr(0, 8'h8C);
        wsr(8'h80);
        rsr(0, 8'h80);
        wp_n = 0;
        wsr(8'h0C);
        rsr(0, 8'h80);
        wr(1, 14'h0100, 8'h5A, 8'h6B);
        mw(2'b00, 14'h0100, 8'h5A, 8'h6B);
        rd(0, 14'h0100);
        wp_n = 1;
        wr(0, 14'h0100, 8'hEE, 8'hEE);
        rd(1, 14'h0100);
        for (int b = 0; b < 4; b++)
        begin
            wsr({4'h0, 2'(b), 2'b00});
            rsr(0, {4'h0, 2'(b), 2'b00});
            for (int k = 0; k < 3; k++)
            begin
                st = starts[k];
                wr(1, st, 8'(16 * b + 2 * k), 8'(16 * b + 2 * k + 1));
                mw(2'(b), st, 8'(16 * b + 2 * k), 8'(16 * b + 2 * k + 1));
            end
            for (int k = 0; k < 3; k++)
                rd(b[0], starts[k]);
        end
        cmd(8'h06);
        rst_n = 1'b0;
        repeat (4) @(posedge clk_sys);
        #2;
        rst_n = 1'b1;
        rsr(0, 8'h00);
        rd(0, 14'h0100);
        mst.sel(0);
        mst.bits(8'hA7, 8);
        mst.bits(8'h05, 8);
        mst.bits(8'h00, 8);
        chk(mst.rxd, 8'hFF);
        chk({7'h0, mst.drv}, 8'h00);
        mst.desel();
        mst.sel(0);
        mst.bits(8'h03, 8);
        mst.bits(8'h01, 8);
        mst.bits(8'h00, 8);
        mst.bits(8'h00, 4);
        mst.pause(1);
        chk({7'h0, so_oe_n}, 8'h01);
        mst.pause(0);
        mst.bits(8'h00, 4);
        chk(mst.rxd, m[14'h0100]);
        mst.desel();
        print_verdict();
    end
endmodule
